// *** design/hlcss_cfg.svh ***
// Register map, field positions, reset values and interrupt bits of the link count
// and slot select bank. Assumes 32-bit APB with word-per-register indexing.
`ifndef HLCSS_CFG_SVH
`define HLCSS_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define HLCSS_IDX_TX_SIG_LINK    10'h10a
`define HLCSS_IDX_RX_COUNT       10'h155
`define HLCSS_IDX_RX_MODE        10'h156
`define HLCSS_IDX_PART_ID        10'h1fe
`define HLCSS_IDX_SILICON_REV    10'h1ff
`define HLCSS_IDX_SLOT_FIRST     10'h300
`define HLCSS_IDX_SLOT_LAST      10'h31f
`define HLCSS_IDX_IRQ_STATUS     10'h3f0
`define HLCSS_IDX_IRQ_ENABLE     10'h3f1
`define HLCSS_IDX_IRQ_CLEAR      10'h3f2

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define HLCSS_PTR_BIT            7
`define HLCSS_CNT_MSB            6
`define HLCSS_SEL_MSB            7
`define HLCSS_SEL_LSB            6
`define HLCSS_DE_MSB             3
`define HLCSS_DE_LSB             2
`define HLCSS_SEL_RESET          2'h2
`define HLCSS_CNT_RESET          7'h00
`define HLCSS_NUM_SLOTS          32
`define HLCSS_IRQ_BITS           2
`define HLCSS_IRQ_EOT            0
`define HLCSS_IRQ_MSG            1

`endif

// *** design/hlcss_pkg.sv ***
// Types shared by the link count and slot select bank.
// Assumes the configuration header is compiled alongside.
package hlcss_pkg;

    // Transmit link controller chosen for a D/E slot
    typedef enum logic [1:0] {
        HLCSS_CTRL1,
        HLCSS_CTRL2,
        HLCSS_CTRL_NONE,
        HLCSS_CTRL3
    } hlcss_sel_e;

    typedef logic [7:0] hlcss_byte_t;

endpackage

// *** design/hlcss_bank.sv ***
// Receive link 3 count/pointer register, identity registers, and the 32
// per-slot transmit controller select registers, behind an APB slave.
// Assumes the receive link engine and slot sequencer sit outside and are
// synchronous to pclk.
//
// Operation
// [R1] Pointer bit names buffer with latest message
// [R2] Bit-oriented: count sets repetitions before end-of-transfer
// [R3] Zero count: receive forever, no interrupt
// [R4] Message-oriented: count reports received byte length
// [R5] Reported length includes header and check octets
// [R6] Part identifier is fixed, writes ignored
// [R7] Revision code read-only, may change
// [R8] Select 00/01/11 picks controller 1/2/3
// [R9] All controllers use slots; only 1 datalink
// [R10] Thirty-two slot registers map slots 0..31
// [R11] Slot data source from signaling select field
// [R12] Slot bits 5 and 4 reserved
// [R13] Reset: select 10, pointer and count zero
// [R14] Pointer and length update together
`timescale 1ns/1ps
`include "hlcss_cfg.svh"

module hlcss_bank
    import hlcss_pkg::*;
#(
    parameter logic [7:0] PART_ID_CODE = 8'h5a,  // Arbitrary value
    parameter logic [7:0] REV_CODE     = 8'h01   // Arbitrary value
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_bos_repeat,
    input  wire logic        rx_mos_done,
    input  wire logic        rx_mos_buffer,
    input  wire logic [6:0]  rx_mos_length,
    input  wire logic [4:0]  tx_slot_index,
    input  wire logic        tx_datalink_bit,
    output logic      [2:0]  tx_ctrl_grant,
    output logic      [1:0]  de_slot_source_select,
    output logic             message_oriented_signal_mode,
    output logic             rx_end_of_transfer_irq,
    output logic             irq
);

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    logic [9:0]  idx;
    logic        setup;
    logic        wr_acc;
    logic        is_slot;
    logic        mapped;
    logic [4:0]  slot_no;

    assign idx     = paddr[11:2];
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite;
    assign is_slot = idx >= `HLCSS_IDX_SLOT_FIRST && idx <= `HLCSS_IDX_SLOT_LAST;
    assign slot_no = idx[4:0];

    // Every defined index answers; others get an error
    always_comb begin
        case (idx)
            `HLCSS_IDX_TX_SIG_LINK, `HLCSS_IDX_RX_COUNT, `HLCSS_IDX_RX_MODE,
            `HLCSS_IDX_PART_ID, `HLCSS_IDX_SILICON_REV, `HLCSS_IDX_IRQ_STATUS,
            `HLCSS_IDX_IRQ_ENABLE, `HLCSS_IDX_IRQ_CLEAR: mapped = 1'b1;
            default: mapped = is_slot;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------------------
    // Software-owned registers
    // ------------------------------------------------------------------------
    logic [1:0]                 de_src_r;
    logic                       mode_r;
    logic [`HLCSS_IRQ_BITS-1:0] irq_en_r;
    hlcss_sel_e                 sel_r [`HLCSS_NUM_SLOTS];

    // Signaling select source field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            de_src_r <= 2'h0;
        end else if (wr_acc && idx == `HLCSS_IDX_TX_SIG_LINK) begin
            de_src_r <= pwdata[`HLCSS_DE_MSB:`HLCSS_DE_LSB];  // [R11]
        end
    end

    // Receive mode and interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r   <= 1'b0;
            irq_en_r <= '0;
        end else if (wr_acc && idx == `HLCSS_IDX_RX_MODE) begin
            mode_r <= pwdata[0];
        end else if (wr_acc && idx == `HLCSS_IDX_IRQ_ENABLE) begin
            irq_en_r <= pwdata[`HLCSS_IRQ_BITS-1:0];
        end
    end

    // One select register per slot, lowest index is slot 0
    generate
        for (genvar s = 0; s < `HLCSS_NUM_SLOTS; s++) begin : g_slot
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sel_r[s] <= hlcss_sel_e'(`HLCSS_SEL_RESET);  // [R13]
                end else if (wr_acc && is_slot && slot_no == 5'(s)) begin  // [R10]
                    sel_r[s] <= hlcss_sel_e'(pwdata[`HLCSS_SEL_MSB:`HLCSS_SEL_LSB]);
                end
            end
        end
    endgenerate

    assign de_slot_source_select        = de_src_r;
    assign message_oriented_signal_mode = mode_r;

    // ------------------------------------------------------------------------
    // Receive count and pointer
    // ------------------------------------------------------------------------
    logic       ptr_r;
    logic [6:0] cnt_r;
    logic [6:0] rep_r;
    logic       cnt_wr;
    logic       mos_upd;
    logic       eot_evt;

    assign cnt_wr  = wr_acc && idx == `HLCSS_IDX_RX_COUNT;
    assign mos_upd = mode_r && rx_mos_done;
    // Final repetition reached; zero count never ends
    assign eot_evt = !mode_r && rx_bos_repeat && cnt_r != 7'h00
                     && rep_r == cnt_r - 7'h01;  // [R2] [R3]

    // Engine update wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_r <= 1'b0;  // [R13]
            cnt_r <= `HLCSS_CNT_RESET;  // [R13]
        end else if (mos_upd) begin
            ptr_r <= rx_mos_buffer;  // [R1] [R14]
            cnt_r <= rx_mos_length;  // [R4] [R5] [R14]
        end else if (cnt_wr) begin
            ptr_r <= pwdata[`HLCSS_PTR_BIT];
            cnt_r <= pwdata[`HLCSS_CNT_MSB:0];
        end
    end

    // Repetition counter, restarts on a new target
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rep_r <= 7'h00;
        end else if (cnt_wr || mode_r || eot_evt) begin
            rep_r <= 7'h00;
        end else if (rx_bos_repeat && cnt_r != 7'h00) begin
            rep_r <= rep_r + 7'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------------
    logic [`HLCSS_IRQ_BITS-1:0] irq_st_r;
    logic [`HLCSS_IRQ_BITS-1:0] irq_set;
    logic [`HLCSS_IRQ_BITS-1:0] irq_clr;

    assign irq_set = {mos_upd, eot_evt};
    assign irq_clr = (wr_acc && idx == `HLCSS_IDX_IRQ_CLEAR)
                     ? pwdata[`HLCSS_IRQ_BITS-1:0] : '0;

    // Sticky bits, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_r <= '0;
        end else begin
            irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
        end
    end

    assign irq                    = |(irq_st_r & irq_en_r);
    assign rx_end_of_transfer_irq = irq_st_r[`HLCSS_IRQ_EOT];

    // ------------------------------------------------------------------------
    // Slot controller grant
    // ------------------------------------------------------------------------
    logic [2:0] grant_r;

    // Datalink bits go to controller 1 only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_r <= 3'h0;
        end else if (tx_datalink_bit) begin
            grant_r <= 3'h1;  // [R9]
        end else begin
            case (sel_r[tx_slot_index])  // [R8]
                HLCSS_CTRL1: grant_r <= 3'h1;
                HLCSS_CTRL2: grant_r <= 3'h2;
                HLCSS_CTRL3: grant_r <= 3'h4;
                default:     grant_r <= 3'h0;
            endcase
        end
    end

    assign tx_ctrl_grant = grant_r;

    // ------------------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------------------
    hlcss_byte_t rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (is_slot) begin
            rd_byte = {sel_r[slot_no], 6'h00};  // [R12]
        end else begin
            case (idx)
                `HLCSS_IDX_TX_SIG_LINK: rd_byte = {4'h0, de_src_r, 2'h0};
                `HLCSS_IDX_RX_COUNT:    rd_byte = {ptr_r, cnt_r};
                `HLCSS_IDX_RX_MODE:     rd_byte = {7'h00, mode_r};
                `HLCSS_IDX_PART_ID:     rd_byte = PART_ID_CODE;  // [R6]
                `HLCSS_IDX_SILICON_REV: rd_byte = REV_CODE;  // [R7]
                `HLCSS_IDX_IRQ_STATUS:  rd_byte = {6'h00, irq_st_r};
                `HLCSS_IDX_IRQ_ENABLE:  rd_byte = {6'h00, irq_en_r};
                default:                rd_byte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_mos_done;
        mode_r && rx_mos_done;
    endsequence

    sequence s_id_read;
        psel && !penable && !pwrite && idx == `HLCSS_IDX_PART_ID;
    endsequence

    chk_ptr_len_pair: assert property (  // [R14]
        @(posedge pclk) disable iff (!presetn)
        s_mos_done |=> ptr_r == $past(rx_mos_buffer) && cnt_r == $past(rx_mos_length))
        else $error("pointer and length not updated together");

    chk_eot_cause: assert property (  // [R2]
        @(posedge pclk) disable iff (!presetn)
        $rose(irq_st_r[0]) |-> $past(!mode_r && rx_bos_repeat && cnt_r != 7'h00))
        else $error("end of transfer without final repetition");

    chk_zero_count_quiet: assert property (  // [R3]
        @(posedge pclk) disable iff (!presetn)
        !mode_r && cnt_r == 7'h00 && !irq_st_r[`HLCSS_IRQ_EOT]
        |=> !irq_st_r[`HLCSS_IRQ_EOT])
        else $error("end of transfer with zero count");

    chk_part_id_read: assert property (  // [R6]
        @(posedge pclk) disable iff (!presetn)
        s_id_read ##1 psel && penable |-> prdata[7:0] == PART_ID_CODE)
        else $error("part identifier read wrong");

    chk_rev_fixed: assert property (  // [R7]
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && idx == `HLCSS_IDX_SILICON_REV
        |=> prdata[7:0] == REV_CODE)
        else $error("revision read wrong");

    chk_grant_decode: assert property (  // [R8]
        @(posedge pclk) disable iff (!presetn)
        !tx_datalink_bit && sel_r[tx_slot_index] == HLCSS_CTRL3 |=> tx_ctrl_grant == 3'h4)
        else $error("controller 3 not granted");

    chk_datalink_ctrl1: assert property (  // [R9]
        @(posedge pclk) disable iff (!presetn)
        tx_datalink_bit |=> tx_ctrl_grant == 3'h1)
        else $error("datalink not given to controller 1");

    chk_slot_write_map: assert property (  // [R10]
        @(posedge pclk) disable iff (!presetn)
        wr_acc && is_slot |=> sel_r[$past(slot_no)] == $past(pwdata[7:6]))
        else $error("slot register write misplaced");

    chk_de_source: assert property (  // [R11]
        @(posedge pclk) disable iff (!presetn)
        wr_acc && idx == `HLCSS_IDX_TX_SIG_LINK |=> de_slot_source_select == $past(pwdata[3:2]))
        else $error("slot source field not taken");

    chk_slot_reserved: assert property (  // [R12]
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && is_slot |=> prdata[5:0] == 6'h00)
        else $error("reserved slot bits not zero");

    chk_reset_values: assert property (  // [R13]
        @(posedge pclk)
        presetn && !$past(presetn) |-> sel_r[0] == HLCSS_CTRL_NONE && cnt_r == 7'h00 && !ptr_r)
        else $error("reset values wrong");

endmodule // hlcss_bank

// *** tb/hlcss_bank_test.sv ***
// Self-checking bench for the link count and slot select bank.
// Assumes the bank, its package and configuration header compile first.
`timescale 1ns/1ps
`include "hlcss_cfg.svh"

module hlcss_bank_test;

    // ------------------------------------------------------------------------
    // Signals and constants
    // ------------------------------------------------------------------------
    localparam logic [7:0] TB_PART_ID = 8'ha7;  // Arbitrary value
    localparam logic [7:0] TB_REV     = 8'h03;  // Arbitrary value
    localparam logic [9:0] CNT_IDX    = `HLCSS_IDX_RX_COUNT;
    localparam logic [9:0] MODE_IDX   = `HLCSS_IDX_RX_MODE;
    localparam logic [9:0] SLOT0      = `HLCSS_IDX_SLOT_FIRST;
    localparam logic [9:0] STAT_IDX   = `HLCSS_IDX_IRQ_STATUS;
    localparam logic [9:0] EN_IDX     = `HLCSS_IDX_IRQ_ENABLE;
    localparam logic [9:0] CLR_IDX    = `HLCSS_IDX_IRQ_CLEAR;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        rx_bos_repeat, rx_mos_done, rx_mos_buffer, tx_datalink_bit;
    logic [6:0]  rx_mos_length;
    logic [4:0]  tx_slot_index;
    logic [2:0]  tx_ctrl_grant;
    logic [1:0]  de_slot_source_select;
    logic        message_oriented_signal_mode, rx_end_of_transfer_irq, irq, err;
    int          n_mismatch, checks_done;

    hlcss_bank #(.PART_ID_CODE(TB_PART_ID), .REV_CODE(TB_REV)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_bos_repeat(rx_bos_repeat),
        .rx_mos_done(rx_mos_done), .rx_mos_buffer(rx_mos_buffer),
        .rx_mos_length(rx_mos_length), .tx_slot_index(tx_slot_index),
        .tx_datalink_bit(tx_datalink_bit), .tx_ctrl_grant(tx_ctrl_grant),
        .de_slot_source_select(de_slot_source_select),
        .message_oriented_signal_mode(message_oriented_signal_mode),
        .rx_end_of_transfer_irq(rx_end_of_transfer_irq), .irq(irq)
    );

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {20'h00000, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read a register and compare
    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input string what);
        apb(1'b0, idx, 32'h0);
        check(what, rd, exp);
    endtask

    // Present a slot and check the grant one cycle later
    task automatic grant_chk(input logic [4:0] slot, input logic dl, input logic [2:0] exp);
        @(posedge pclk);
        tx_slot_index   <= slot;
        tx_datalink_bit <= dl;
        @(posedge pclk);
        #1;
        check("slot grant", {29'h0, tx_ctrl_grant}, {29'h0, exp});
    endtask

    // Bit-oriented repetition pulses, one idle cycle apart
    task automatic bos_pulses(input int n);
        repeat (n) begin
            @(posedge pclk);
            rx_bos_repeat <= 1'b1;
            @(posedge pclk);
            rx_bos_repeat <= 1'b0;
        end
        #1;
    endtask

    // One completed message-oriented message
    task automatic mos_msg(input logic buf_sel, input logic [6:0] len);
        @(posedge pclk);
        rx_mos_done   <= 1'b1;
        rx_mos_buffer <= buf_sel;
        rx_mos_length <= len;
        @(posedge pclk);
        rx_mos_done   <= 1'b0;
    endtask

    // Counts, verdict and end of run
    task automatic print_verdict;
        $display("checks done %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------------------
    // Clock at 40 MHz
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, rx_bos_repeat, rx_mos_done} = 6'h00;
        {rx_mos_buffer, tx_datalink_bit} = 2'h0;
        {paddr, pwdata} = 64'h0;
        rx_mos_length = 7'h00;
        tx_slot_index = 5'h00;
        n_mismatch = 0;
        checks_done = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, identity, unmapped access
        rd_chk(CNT_IDX, 32'h00, "count reset");
        rd_chk(SLOT0, 32'h80, "slot select reset");
        apb(1'b1, `HLCSS_IDX_PART_ID, 32'hff);
        rd_chk(`HLCSS_IDX_PART_ID, {24'h0, TB_PART_ID}, "part id");
        rd_chk(`HLCSS_IDX_SILICON_REV, {24'h0, TB_REV}, "revision");
        apb(1'b1, 10'h000, 32'h1);
        check("unmapped error", {31'h0, err}, 32'h1);
        // Controller selects on slots 0 to 3 and the last slot
        apb(1'b1, SLOT0, 32'h00);
        apb(1'b1, SLOT0 + 10'h1, 32'h40);
        apb(1'b1, SLOT0 + 10'h3, 32'h70);
        apb(1'b1, `HLCSS_IDX_SLOT_LAST, 32'hc0);
        grant_chk(5'd0, 1'b0, 3'b001);
        grant_chk(5'd1, 1'b0, 3'b010);
        grant_chk(5'd2, 1'b0, 3'b000);
        grant_chk(5'd3, 1'b0, 3'b010);
        grant_chk(5'd31, 1'b0, 3'b100);
        grant_chk(5'd31, 1'b1, 3'b001);
        // Slot data source field
        apb(1'b1, `HLCSS_IDX_TX_SIG_LINK, 32'h0c);
        #1;
        check("slot source", {30'h0, de_slot_source_select}, 32'h3);
        apb(1'b1, `HLCSS_IDX_TX_SIG_LINK, 32'h04);
        #1;
        check("slot source", {30'h0, de_slot_source_select}, 32'h1);
        // Message-oriented length and pointer
        apb(1'b1, MODE_IDX, 32'h1);
        #1;
        check("mode", {31'h0, message_oriented_signal_mode}, 32'h1);
        mos_msg(1'b1, 7'h25);
        rd_chk(CNT_IDX, 32'ha5, "pointer and length");
        mos_msg(1'b0, 7'h7f);
        rd_chk(CNT_IDX, 32'h7f, "pointer and length");
        rd_chk(STAT_IDX, 32'h2, "status after message");
        apb(1'b1, EN_IDX, 32'h2);
        #1;
        check("message irq", {31'h0, irq}, 32'h1);
        // Bit-oriented repetition count with interrupt
        apb(1'b1, MODE_IDX, 32'h0);
        apb(1'b1, CLR_IDX, 32'h3);
        apb(1'b1, EN_IDX, 32'h1);
        apb(1'b1, CNT_IDX, 32'h3);
        bos_pulses(2);
        check("early end of transfer", {31'h0, irq}, 32'h0);
        bos_pulses(1);
        check("end of transfer", {31'h0, rx_end_of_transfer_irq}, 32'h1);
        check("irq line", {31'h0, irq}, 32'h1);
        apb(1'b1, EN_IDX, 32'h0);
        #1;
        check("masked irq", {31'h0, irq}, 32'h0);
        apb(1'b1, CLR_IDX, 32'h1);
        #1;
        check("cleared status", {31'h0, rx_end_of_transfer_irq}, 32'h0);
        bos_pulses(3);
        check("restarted count", {31'h0, rx_end_of_transfer_irq}, 32'h1);
        // Zero count never ends
        apb(1'b1, CLR_IDX, 32'h1);
        apb(1'b1, CNT_IDX, 32'h0);
        bos_pulses(130);
        check("unlimited count", {31'h0, rx_end_of_transfer_irq}, 32'h0);
        rd_chk(STAT_IDX, 32'h0, "status unlimited");
        // Reset in mid-run brings back the defaults
        apb(1'b1, CNT_IDX, 32'h85);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`HLCSS_IDX_SLOT_LAST, 32'h80, "slot select after reset");
        rd_chk(CNT_IDX, 32'h00, "count after reset");
        check("source after reset", {30'h0, de_slot_source_select}, 32'h0);
        print_verdict();
    end

endmodule // hlcss_bank_test
